// file: rtl/hsq_defines.svh
`ifndef HSQ_DEFINES_SVH
`define HSQ_DEFINES_SVH

// supported method numbers
`define HSQ_METHOD_W 8
`define HSQ_METHOD_FIRST 8'h09
`define HSQ_METHOD_LAST 8'h0e
`define HSQ_METHOD_09 8'h09
`define HSQ_METHOD_10 8'h0a
`define HSQ_METHOD_11 8'h0b
`define HSQ_METHOD_12 8'h0c
`define HSQ_METHOD_13 8'h0d
`define HSQ_METHOD_14 8'h0e
`define HSQ_METHOD_17 8'h11

// search path through a method
`define HSQ_PATH_PLAIN 2'h0
`define HSQ_PATH_LIMIT 2'h1
`define HSQ_PATH_ACTIVE 2'h2

// step code {forward, high speed, wait for rising edge}
`define HSQ_FHR 3'h7
`define HSQ_RHR 3'h3
`define HSQ_FLR 3'h5
`define HSQ_FLF 3'h4
`define HSQ_RLR 3'h1
`define HSQ_RLF 3'h0
`define HSQ_STEP_FWD 2
`define HSQ_STEP_FAST 1
`define HSQ_STEP_RISE 0

// a path is up to four steps plus a step count
`define HSQ_LEN_LSB 12
`define HSQ_STEP_W 3
`define HSQ_LEN_W 3
`define HSQ_IDX_W 2
`define HSQ_IDX_ONE 2'h1
`define HSQ_PATH_NONE 15'h0000

`endif

// file: rtl/hsq_pkg.sv
package hsq_pkg;
	typedef enum logic [1:0] {
		HSQ_IDLE = 2'b00,
		HSQ_RUN = 2'b01,
		HSQ_SEEK = 2'b10,
		HSQ_DONE = 2'b11
	} hsq_state_type;

	typedef logic [2:0] hsq_step_type;
	typedef logic [14:0] hsq_path_type;
endpackage : hsq_pkg

// file: rtl/hsq_edge.sv
`timescale 1ns/1ps
module hsq_edge #(
	parameter int WIDTH = 4
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] sig,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	typedef struct packed {
		logic [WIDTH-1:0] now;
		logic [WIDTH-1:0] prev;
	} hsq_edge_st_type;

	hsq_edge_st_type st_q;
	hsq_edge_st_type st_d;

	initial begin
		if (WIDTH < 1) $error("hsq_edge: WIDTH must be at least 1");
	end

	always_comb begin
		st_d.now = sig;
		st_d.prev = st_q.now;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// edges come from registered samples only, never from the raw pins
	assign level = st_q.now;
	assign rise = st_q.now & ~st_q.prev;
	assign fall = ~st_q.now & st_q.prev;
endmodule : hsq_edge

// file: rtl/hsq_homing.sv
// Functional notes
// R01: Methods 9-14 decelerate on the home switch and home on first index.
// R02: M9 plain: fwd high, rise slow fwd, fall rev low, index after rise.
// R03: M9 limit hit: reverse, rise slow fwd, fall rev low, index after rise.
// R04: M9/M12 switch active: fwd low, fall reverse, index after rise.
// R05: M10 plain: fwd high, rise slow, fall rev, rise fwd, index after fall.
// R06: M10 limit hit: reverse, rise slow forward, index after fall.
// R07: M10/M11 switch active: forward low, index after falling edge.
// R08: M11 plain: reverse high, rise slow forward, index after fall.
// R09: M11 limit hit: fwd, rise slow, fall rev, rise fwd, index after fall.
// R10: M12 plain: rev high (fwd on limit), rise fwd low, fall rev, index.
// R11: M13 plain: rev high, rise slow rev, fall fwd, index after rise.
// R12: M13/M14 reverse limit hit: forward high, switch rise slow reverse.
// R13: M13 after limit reversal: fall forward, index after next rise.
// R14: M13 switch active: rev low, fall forward, index after rise.
// R15: M14 plain: rev high, rise slow, fall fwd, rise rev, index after fall.
// R16: M14 after limit reversal: keep reverse, index after falling edge.
// R17: M14 switch active: reverse low, index after falling edge.
// R18: M17 homes and decelerates on reverse limit, no index used.
// R19: M17 inactive: rev high, rise slow forward, stop on fall.
// R20: M17 active: forward low, stop on falling edge of reverse limit.
// R21: High speed is switch search speed, low is index search speed.
// R22: Edges from sampled inputs; done flagged once stopped at home event.
// R23: Each direction or speed change is applied before the next edge.
`timescale 1ns/1ps
`include "hsq_defines.svh"
module hsq_homing #(
	parameter int SPEED_W = 16
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic homing_start,
	input wire logic [`HSQ_METHOD_W-1:0] homing_method,
	input wire logic home_switch_input,
	input wire logic reverse_travel_limit_input,
	input wire logic forward_travel_limit_input,
	input wire logic index_pulse,
	input wire logic [SPEED_W-1:0] switch_search_speed,
	input wire logic [SPEED_W-1:0] index_search_speed,
	output logic move_enable,
	output logic move_forward,
	output logic [SPEED_W-1:0] speed_cmd,
	output logic homing_busy,
	output logic homing_done,
	output logic homing_error
);
	typedef struct packed {
		hsq_pkg::hsq_state_type state;
		logic [`HSQ_METHOD_W-1:0] method;
		logic [1:0] path;
		logic [`HSQ_IDX_W-1:0] idx;
		logic enable;
		logic forward;
		logic fast;
		logic [SPEED_W-1:0] speed;
		logic done;
		logic error;
	} hsq_st_type;

	hsq_st_type st_q;
	hsq_st_type st_d;

	logic [3:0] lvl;
	logic [3:0] rise;
	logic [3:0] fall;

	initial begin
		if (SPEED_W < 1) $error("hsq_homing: SPEED_W must be at least 1");
	end

	hsq_edge #(
		.WIDTH(4)
	) u_edge (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.sig({index_pulse, forward_travel_limit_input, reverse_travel_limit_input,
			home_switch_input}),
		.level(lvl),
		.rise(rise),
		.fall(fall)
	); // R22

	function automatic hsq_pkg::hsq_path_type mk(input logic [`HSQ_LEN_W-1:0] len,
		input hsq_pkg::hsq_step_type s0, input hsq_pkg::hsq_step_type s1,
		input hsq_pkg::hsq_step_type s2, input hsq_pkg::hsq_step_type s3);
		mk = {len, s3, s2, s1, s0};
	endfunction : mk

	// step table; the last step's edge arms the index search (or stops, for 17)
	function automatic hsq_pkg::hsq_path_type path_of(input logic [`HSQ_METHOD_W-1:0] m,
		input logic [1:0] p);
		path_of = `HSQ_PATH_NONE;
		case ({m, p})
			{`HSQ_METHOD_09, `HSQ_PATH_PLAIN}:
				path_of = mk(3'h3, `HSQ_FHR, `HSQ_FLF, `HSQ_RLR, `HSQ_RLR); // R02
			{`HSQ_METHOD_09, `HSQ_PATH_LIMIT}:
				path_of = mk(3'h3, `HSQ_RHR, `HSQ_FLF, `HSQ_RLR, `HSQ_RLR); // R03
			{`HSQ_METHOD_09, `HSQ_PATH_ACTIVE},
			{`HSQ_METHOD_12, `HSQ_PATH_ACTIVE}:
				path_of = mk(3'h2, `HSQ_FLF, `HSQ_RLR, `HSQ_RLR, `HSQ_RLR); // R04
			{`HSQ_METHOD_10, `HSQ_PATH_PLAIN}:
				path_of = mk(3'h4, `HSQ_FHR, `HSQ_FLF, `HSQ_RLR, `HSQ_FLF); // R05
			{`HSQ_METHOD_10, `HSQ_PATH_LIMIT}:
				path_of = mk(3'h2, `HSQ_RHR, `HSQ_FLF, `HSQ_FLF, `HSQ_FLF); // R06
			{`HSQ_METHOD_10, `HSQ_PATH_ACTIVE},
			{`HSQ_METHOD_11, `HSQ_PATH_ACTIVE}:
				path_of = mk(3'h1, `HSQ_FLF, `HSQ_FLF, `HSQ_FLF, `HSQ_FLF); // R07
			{`HSQ_METHOD_11, `HSQ_PATH_PLAIN}:
				path_of = mk(3'h2, `HSQ_RHR, `HSQ_FLF, `HSQ_FLF, `HSQ_FLF); // R08
			{`HSQ_METHOD_11, `HSQ_PATH_LIMIT}:
				path_of = mk(3'h4, `HSQ_FHR, `HSQ_FLF, `HSQ_RLR, `HSQ_FLF); // R09
			{`HSQ_METHOD_12, `HSQ_PATH_PLAIN}:
				path_of = mk(3'h3, `HSQ_RHR, `HSQ_FLF, `HSQ_RLR, `HSQ_RLR); // R10
			{`HSQ_METHOD_12, `HSQ_PATH_LIMIT}:
				path_of = mk(3'h3, `HSQ_FHR, `HSQ_FLF, `HSQ_RLR, `HSQ_RLR); // R10
			{`HSQ_METHOD_13, `HSQ_PATH_PLAIN}:
				path_of = mk(3'h3, `HSQ_RHR, `HSQ_RLF, `HSQ_FLR, `HSQ_FLR); // R11
			{`HSQ_METHOD_13, `HSQ_PATH_LIMIT}:
				path_of = mk(3'h3, `HSQ_FHR, `HSQ_RLF, `HSQ_FLR, `HSQ_FLR); // R12 R13
			{`HSQ_METHOD_13, `HSQ_PATH_ACTIVE}:
				path_of = mk(3'h2, `HSQ_RLF, `HSQ_FLR, `HSQ_FLR, `HSQ_FLR); // R14
			{`HSQ_METHOD_14, `HSQ_PATH_PLAIN}:
				path_of = mk(3'h4, `HSQ_RHR, `HSQ_RLF, `HSQ_FLR, `HSQ_RLF); // R15
			{`HSQ_METHOD_14, `HSQ_PATH_LIMIT}:
				path_of = mk(3'h2, `HSQ_FHR, `HSQ_RLF, `HSQ_RLF, `HSQ_RLF); // R12 R16
			{`HSQ_METHOD_14, `HSQ_PATH_ACTIVE}:
				path_of = mk(3'h1, `HSQ_RLF, `HSQ_RLF, `HSQ_RLF, `HSQ_RLF); // R17
			{`HSQ_METHOD_17, `HSQ_PATH_PLAIN}:
				path_of = mk(3'h2, `HSQ_RHR, `HSQ_FLF, `HSQ_FLF, `HSQ_FLF); // R19
			{`HSQ_METHOD_17, `HSQ_PATH_ACTIVE}:
				path_of = mk(3'h1, `HSQ_FLF, `HSQ_FLF, `HSQ_FLF, `HSQ_FLF); // R20
			default:
				path_of = `HSQ_PATH_NONE;
		endcase
	endfunction : path_of

	function automatic hsq_pkg::hsq_step_type step_of(input hsq_pkg::hsq_path_type pw,
		input logic [`HSQ_IDX_W-1:0] i);
		step_of = pw[i*`HSQ_STEP_W +: `HSQ_STEP_W];
	endfunction : step_of

	function automatic logic method_ok(input logic [`HSQ_METHOD_W-1:0] m);
		method_ok = (m >= `HSQ_METHOD_FIRST && m <= `HSQ_METHOD_LAST) ||
			m == `HSQ_METHOD_17;
	endfunction : method_ok

	logic is17_cur;
	logic is17_new;
	logic sw_lvl_new;
	logic sw_rise;
	logic sw_fall;
	logic limit_hit;
	logic [1:0] start_path;
	logic [`HSQ_LEN_W-1:0] cur_len;
	hsq_pkg::hsq_path_type cur_path;
	hsq_pkg::hsq_path_type new_path;
	hsq_pkg::hsq_step_type cur_step;
	hsq_pkg::hsq_step_type nxt_step;

	always_comb begin
		is17_cur = st_q.method == `HSQ_METHOD_17;
		is17_new = homing_method == `HSQ_METHOD_17;
		// method 17 treats the reverse limit as its switch
		sw_lvl_new = is17_new ? lvl[1] : lvl[0]; // R18
		sw_rise = is17_cur ? rise[1] : rise[0]; // R18
		sw_fall = is17_cur ? fall[1] : fall[0]; // R18
		// forward-starting methods watch the forward limit, others the reverse one
		limit_hit = (st_q.method <= `HSQ_METHOD_10) ? rise[2] : rise[1];
		start_path = sw_lvl_new ? `HSQ_PATH_ACTIVE : `HSQ_PATH_PLAIN;
		new_path = path_of(homing_method, start_path);
		cur_path = path_of(st_q.method, st_q.path);
		cur_len = cur_path[`HSQ_LEN_LSB +: `HSQ_LEN_W];
		cur_step = step_of(cur_path, st_q.idx);
		nxt_step = step_of(cur_path, st_q.idx + `HSQ_IDX_ONE);

		st_d = st_q;
		case (st_q.state)
			hsq_pkg::HSQ_IDLE, hsq_pkg::HSQ_DONE: begin
				if (homing_start) begin
					st_d.done = 1'b0;
					st_d.error = !method_ok(homing_method);
					if (method_ok(homing_method)) begin
						st_d.state = hsq_pkg::HSQ_RUN;
						st_d.method = homing_method;
						st_d.path = start_path;
						st_d.idx = '0;
						st_d.enable = 1'b1;
						st_d.forward = new_path[`HSQ_STEP_FWD];
						st_d.fast = new_path[`HSQ_STEP_FAST];
					end
				end
			end
			hsq_pkg::HSQ_RUN: begin
				// one event per cycle; the new step is visible before the next edge
				if (st_q.path == `HSQ_PATH_PLAIN && st_q.idx == '0 && !is17_cur &&
					limit_hit) begin
					st_d.path = `HSQ_PATH_LIMIT; // R03 R06 R09 R10 R12
					st_d.forward = !st_q.forward;
				end else if (cur_step[`HSQ_STEP_RISE] ? sw_rise : sw_fall) begin // R23
					if ({1'b0, st_q.idx} + 3'h1 == cur_len) begin
						if (is17_cur) begin
							st_d.state = hsq_pkg::HSQ_DONE; // R19 R20
							st_d.enable = 1'b0;
							st_d.done = 1'b1;
						end else begin
							st_d.state = hsq_pkg::HSQ_SEEK; // R01
						end
					end else begin
						st_d.idx = st_q.idx + `HSQ_IDX_ONE;
						st_d.forward = nxt_step[`HSQ_STEP_FWD];
						st_d.fast = nxt_step[`HSQ_STEP_FAST];
					end
				end
			end
			hsq_pkg::HSQ_SEEK: begin
				// only index pulses after the arming edge count
				if (rise[3]) begin
					st_d.state = hsq_pkg::HSQ_DONE; // R01 R22
					st_d.enable = 1'b0;
					st_d.done = 1'b1;
				end
			end
			default: begin
				st_d.state = hsq_pkg::HSQ_IDLE;
				st_d.enable = 1'b0;
			end
		endcase
		// speed follows live settings so a retune takes effect mid-search
		st_d.speed = st_d.fast ? switch_search_speed : index_search_speed; // R21
		// speed register is cleared whenever motion is off, so the output needs no gate
		if (!st_d.enable) begin
			st_d.speed = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign move_enable = st_q.enable;
	assign move_forward = st_q.forward;
	assign speed_cmd = st_q.speed;
	assign homing_busy = st_q.state == hsq_pkg::HSQ_RUN || st_q.state == hsq_pkg::HSQ_SEEK;
	assign homing_done = st_q.done;
	assign homing_error = st_q.error;
endmodule : hsq_homing

// file: tb/hsq_homing_props.sv
`timescale 1ns/1ps
`include "hsq_defines.svh"
module hsq_homing_props #(
	parameter int SPEED_W = 16
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic homing_start,
	input wire logic [`HSQ_METHOD_W-1:0] homing_method,
	input wire logic home_switch_input,
	input wire logic reverse_travel_limit_input,
	input wire logic forward_travel_limit_input,
	input wire logic index_pulse,
	input wire logic [SPEED_W-1:0] switch_search_speed,
	input wire logic [SPEED_W-1:0] index_search_speed,
	input wire logic move_enable,
	input wire logic move_forward,
	input wire logic [SPEED_W-1:0] speed_cmd,
	input wire logic homing_busy,
	input wire logic homing_done,
	input wire logic homing_error
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic take;
	logic ok_m;
	assign take = homing_start && !homing_busy;
	assign ok_m = homing_method inside {[8'h09:8'h0e], 8'h11};
	a_bad_method: assert property (take && !ok_m |=> homing_error && !move_enable)
		else $error("bad method not refused");
	a_start_moves: assert property (take && ok_m |=>
		move_enable && homing_busy && !homing_done && !homing_error) else $error("start lost");
	a_fwd_first: assert property (take && homing_method inside {8'h09, 8'h0a} |=> move_forward)
		else $error("first move not forward");
	a_rev_first: assert property (take && homing_method inside {8'h0d, 8'h0e} |=> !move_forward)
		else $error("first move not reverse");
	a_speed_pick: assert property (move_enable |->
		speed_cmd == switch_search_speed || speed_cmd == index_search_speed) else $error("bad speed");
	a_stop_zero: assert property (!move_enable |-> speed_cmd == '0)
		else $error("speed while stopped");
	a_done_halts: assert property ($rose(homing_done) |-> !move_enable && !homing_busy)
		else $error("done while moving");
	a_done_cause: assert property ($rose(homing_done) |->
		$past(index_pulse, 2)
		|| ($past(reverse_travel_limit_input, 3) && !$past(reverse_travel_limit_input, 2)))
		else $error("done without home event");
	a_done_holds: assert property (homing_done && !homing_start |=> homing_done)
		else $error("done dropped");
	c_done: cover property ($rose(homing_done));
	c_error: cover property ($rose(homing_error));
	c_limit: cover property (homing_busy && $rose(forward_travel_limit_input));
endmodule : hsq_homing_props

bind hsq_homing hsq_homing_props #(.SPEED_W(SPEED_W)) u_props (.sys_clk(sys_clk), .nrst(nrst),
	.homing_start(homing_start), .homing_method(homing_method),
	.home_switch_input(home_switch_input), .reverse_travel_limit_input(reverse_travel_limit_input),
	.forward_travel_limit_input(forward_travel_limit_input), .index_pulse(index_pulse),
	.switch_search_speed(switch_search_speed), .index_search_speed(index_search_speed),
	.move_enable(move_enable), .move_forward(move_forward), .speed_cmd(speed_cmd),
	.homing_busy(homing_busy), .homing_done(homing_done), .homing_error(homing_error));

// file: tb/hsq_axis_model.sv
`timescale 1ns/1ps
module hsq_axis_model (
	input wire logic sys_clk,
	input wire logic load,
	input wire logic signed [15:0] load_pos,
	input wire logic move_enable,
	input wire logic move_forward,
	input wire logic [15:0] speed_cmd,
	output logic signed [15:0] pos,
	output logic home_switch_input,
	output logic reverse_travel_limit_input,
	output logic forward_travel_limit_input,
	output logic index_pulse
);
	initial pos = 16'sh0000;
	always @(posedge sys_clk) begin
		if (load) begin
			pos <= load_pos;
		end else if (move_enable) begin
			pos <= move_forward ? pos + speed_cmd : pos - speed_cmd;
		end
	end
	// cams at fixed places; switch spans one index mark so side shows which edge armed
	assign home_switch_input = (pos >= 16'sh00c8) && (pos <= 16'sh012c);
	assign reverse_travel_limit_input = pos <= 16'sh0014;
	assign forward_travel_limit_input = pos >= 16'sh01e0;
	// mark every 64 counts; only seen while passing, a standing axis gives no pulse
	assign index_pulse = move_enable && (pos[5:0] == 6'h00);
endmodule : hsq_axis_model

// file: tb/tb_hsq_homing.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module tb_hsq_homing;
	localparam logic [15:0] HI = 16'h0004;
	localparam logic [15:0] LO = 16'h0001;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic homing_start = 1'b0;
	logic [7:0] homing_method = 8'h00;
	logic load = 1'b0;
	logic signed [15:0] load_pos = 16'sh0000;
	logic signed [15:0] pos;
	logic hs, rl, fl, ix, en, fw, bz, dn, er;
	logic [15:0] sp;
	int fails = 0;
	int num_checks = 0;
	initial forever #50 sys_clk = ~sys_clk;
	hsq_homing u_dut (.sys_clk(sys_clk), .nrst(nrst), .homing_start(homing_start),
		.homing_method(homing_method), .home_switch_input(hs), .reverse_travel_limit_input(rl),
		.forward_travel_limit_input(fl), .index_pulse(ix), .switch_search_speed(HI),
		.index_search_speed(LO), .move_enable(en), .move_forward(fw), .speed_cmd(sp),
		.homing_busy(bz), .homing_done(dn), .homing_error(er));
	hsq_axis_model u_axis (.sys_clk(sys_clk), .load(load), .load_pos(load_pos),
		.move_enable(en), .move_forward(fw), .speed_cmd(sp), .pos(pos), .home_switch_input(hs),
		.reverse_travel_limit_input(rl), .forward_travel_limit_input(fl), .index_pulse(ix));
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out
	// result {first dir, first fast, final dir, side of switch: 0 below, 1 on, 2 above}
	task automatic run_case(input logic [7:0] m, input logic signed [15:0] p, output logic [4:0] r);
		int n;
		logic [1:0] i;
		@(negedge sys_clk);
		load = 1'b1;
		load_pos = p;
		@(negedge sys_clk);
		load = 1'b0;
		// samplers need settled inputs before the start level is judged
		repeat (3) @(negedge sys_clk);
		homing_method = m;
		homing_start = 1'b1;
		@(negedge sys_clk);
		homing_start = 1'b0;
		@(negedge sys_clk);
		i = {fw, sp === HI};
		`CHK("busy", 1'b1, bz)
		n = 0;
		while (dn !== 1'b1 && n < 4000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 4000) begin
			`CHK("timeout done", 1'b1, dn)
			close_out();
		end
		`CHK("stop speed", 16'h0000, sp)
		r = {i, fw, pos < 16'sh00c8 ? 2'h0 : (pos <= 16'sh012c ? 2'h1 : 2'h2)};
	endtask : run_case
	task automatic t_bad();
		@(negedge sys_clk);
		homing_method = 8'h0f;
		homing_start = 1'b1;
		@(negedge sys_clk);
		homing_start = 1'b0;
		@(negedge sys_clk);
		`CHK("error", 1'b1, er)
		`CHK("idle", 1'b0, en)
	endtask : t_bad
	task automatic t_m09();
		logic [4:0] r;
		run_case(8'h09, 16'sh0064, r);
		`CHK("m9 plain", 5'h19, r)
		run_case(8'h09, 16'sh0190, r);
		`CHK("m9 limit", 5'h19, r)
		run_case(8'h09, 16'sh00fa, r);
		`CHK("m9 active", 5'h11, r)
	endtask : t_m09
	task automatic t_m10();
		logic [4:0] r;
		run_case(8'h0a, 16'sh0064, r);
		`CHK("m10 plain", 5'h1e, r)
		run_case(8'h0a, 16'sh0190, r);
		`CHK("m10 limit", 5'h1e, r)
		run_case(8'h0a, 16'sh00fa, r);
		`CHK("m10 active", 5'h16, r)
	endtask : t_m10
	task automatic t_m11();
		logic [4:0] r;
		run_case(8'h0b, 16'sh0190, r);
		`CHK("m11 plain", 5'h0e, r)
		run_case(8'h0b, 16'sh0064, r);
		`CHK("m11 limit", 5'h0e, r)
		run_case(8'h0b, 16'sh00fa, r);
		`CHK("m11 active", 5'h16, r)
	endtask : t_m11
	task automatic t_m12();
		logic [4:0] r;
		run_case(8'h0c, 16'sh0190, r);
		`CHK("m12 plain", 5'h09, r)
		run_case(8'h0c, 16'sh0064, r);
		`CHK("m12 limit", 5'h09, r)
		run_case(8'h0c, 16'sh00fa, r);
		`CHK("m12 active", 5'h11, r)
	endtask : t_m12
	task automatic t_m13();
		logic [4:0] r;
		run_case(8'h0d, 16'sh0190, r);
		`CHK("m13 plain", 5'h0d, r)
		run_case(8'h0d, 16'sh0064, r);
		`CHK("m13 limit", 5'h0d, r)
		run_case(8'h0d, 16'sh00fa, r);
		`CHK("m13 active", 5'h05, r)
	endtask : t_m13
	task automatic t_m14();
		logic [4:0] r;
		run_case(8'h0e, 16'sh0190, r);
		`CHK("m14 plain", 5'h08, r)
		run_case(8'h0e, 16'sh0064, r);
		`CHK("m14 limit", 5'h08, r)
		run_case(8'h0e, 16'sh00fa, r);
		`CHK("m14 active", 5'h00, r)
	endtask : t_m14
	task automatic t_m17();
		logic [4:0] r;
		run_case(8'h11, 16'sh0064, r);
		`CHK("m17 plain", 5'h0c, r)
		run_case(8'h11, 16'sh000a, r);
		`CHK("m17 active", 5'h14, r)
	endtask : t_m17
	initial begin
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
		t_bad();
		t_m09();
		t_m10();
		t_m11();
		t_m12();
		t_m13();
		t_m14();
		t_m17();
		close_out();
	end
endmodule : tb_hsq_homing
